/* common/bss_defines.vh */
`ifndef BSS_DEFINES_VH
`define BSS_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define BSS_REG_CTRL 4'h0
`define BSS_REG_STATUS 4'h4
`define BSS_REG_IRQ_STAT 4'h8
`define BSS_REG_IRQ_MASK 4'hc

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define BSS_CTRL_SEQ_ON 0
`define BSS_CTRL_RESET 32'h00000001

// ----------------------------------------
// Interrupt status fields
// ----------------------------------------
`define BSS_IRQ_FAULT 0
`define BSS_IRQ_PWR_OK 1
`define BSS_IRQ_SHUTDOWN 2
`define BSS_IRQ_WIDTH 3
`define BSS_IRQ_MASK_RESET 3'h0

// ----------------------------------------
// Timing, clock period in ns
// ----------------------------------------
`define BSS_CLK_PERIOD_NS 40
`define BSS_LINEAR_CHARGE_PHASE_TWO_LIMIT_US 1024
`define BSS_SOFT_LIMIT_MS 2
`define BSS_FAULT_WAIT_MS 1
`define BSS_LINEAR_CHARGE_PHASE_TWO_CYCLES ((`BSS_LINEAR_CHARGE_PHASE_TWO_LIMIT_US * 1000) / `BSS_CLK_PERIOD_NS)
`define BSS_SOFT_CYCLES ((`BSS_SOFT_LIMIT_MS * 1000000) / `BSS_CLK_PERIOD_NS)
`define BSS_FAULT_CYCLES ((`BSS_FAULT_WAIT_MS * 1000000) / `BSS_CLK_PERIOD_NS)

// ----------------------------------------
// Sequencer states
// ----------------------------------------
`define BSS_ST_IDLE 4'h0
`define BSS_ST_LINEAR_CHARGE_PHASE_ONE 4'h1
`define BSS_ST_LINEAR_CHARGE_PHASE_TWO 4'h2
`define BSS_ST_START 4'h3
`define BSS_ST_SOFT 4'h4
`define BSS_ST_BOOST 4'h5
`define BSS_ST_BYPASS 4'h6
`define BSS_ST_FAULT 4'h7
`define BSS_ST_FORCE 4'h8

`endif

/* core/bss_timer.v */
`timescale 1ns/10ps
`default_nettype none

module bss_timer (
  // Clock and reset
  input wire i_clock,
  input wire i_nrst,
  // Control
  input wire i_run,
  input wire [16:0] i_limit,
  // Status
  output reg o_expired
);

  reg [16:0] count;

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      count <= 17'h00000;
      o_expired <= 1'b0;
    end else if (!i_run) begin
      count <= 17'h00000;
      o_expired <= 1'b0;
    end else if (count >= i_limit) begin
      o_expired <= 1'b1;
    end else begin
      count <= count + 17'h00001;
    end
  end

endmodule

`default_nettype wire

/* core/bss_sequencer.v */
`timescale 1ns/10ps
`default_nettype none
`include "bss_defines.vh"

module bss_sequencer (
  // Clock and reset
  input wire i_clock,
  input wire i_nrst,
  // Mode pins
  input wire i_enable,
  input wire i_force_pass_low,
  input wire i_output_level_pick,
  // Analog comparators
  input wire i_supply_in_above_out,
  input wire i_supply_in_above_target,
  input wire i_input_undervoltage_lockout,
  input wire i_out_at_target,
  input wire i_overcurrent,
  input wire i_overtemp,
  // Power-good open drain
  output reg o_power_ok_flag_out,
  output reg o_power_ok_flag_oe,
  // Power stage controls
  output reg o_linear_charge_phase_one,
  output reg o_linear_charge_phase_two,
  output reg o_switch_enable,
  output reg o_ref_ramp,
  output reg o_bypass_fet_on,
  output reg o_target_high,
  output reg o_path_open,
  // AXI4-Lite write address
  input wire [3:0] i_s_axi_awaddr,
  input wire i_s_axi_awvalid,
  output reg o_s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  input wire i_s_axi_wvalid,
  output reg o_s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] o_s_axi_bresp,
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  // AXI4-Lite read address
  input wire [3:0] i_s_axi_araddr,
  input wire i_s_axi_arvalid,
  output reg o_s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready,
  // Interrupt
  output reg o_irq
);

  reg [3:0] state;
  reg [3:0] next_state;
  reg seq_on;
  reg [2:0] irq_stat;
  reg [2:0] irq_mask;
  reg [2:0] irq_set;
  reg prev_above;
  reg [3:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg w_held;
  wire linear_charge_phase_two_expired;
  wire soft_expired;
  wire fault_expired;
  wire active;
  wire overload;
  wire do_write;
  wire [2:0] clear_bits;
  localparam [31:0] LINEAR_CHARGE_PHASE_TWO_COUNT = `BSS_LINEAR_CHARGE_PHASE_TWO_CYCLES;
  localparam [31:0] SOFT_COUNT = `BSS_SOFT_CYCLES;
  localparam [31:0] FAULT_COUNT = `BSS_FAULT_CYCLES;

  assign active = i_enable && seq_on;
  assign overload = i_overcurrent || i_overtemp;

  // ----------------------------------------
  // Phase timers
  // ----------------------------------------
  // phase two limit
  bss_timer u_linear_charge_phase_two_timer (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_run(state == `BSS_ST_LINEAR_CHARGE_PHASE_TWO),
    .i_limit(LINEAR_CHARGE_PHASE_TWO_COUNT[16:0]),
    .o_expired(linear_charge_phase_two_expired)
  );

  bss_timer u_soft_timer (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_run(state == `BSS_ST_SOFT),
    .i_limit(SOFT_COUNT[16:0]),
    .o_expired(soft_expired)
  );

  bss_timer u_fault_timer (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_run(state == `BSS_ST_FAULT),
    .i_limit(FAULT_COUNT[16:0]),
    .o_expired(fault_expired)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always @* begin
    next_state = state;
    if (!active) begin
      next_state = `BSS_ST_IDLE;
    end else if (!i_force_pass_low) begin
      next_state = `BSS_ST_FORCE;
    end else begin
      case (state)
        `BSS_ST_IDLE: begin
          if (!i_input_undervoltage_lockout && i_supply_in_above_out && !prev_above) begin
            next_state = `BSS_ST_LINEAR_CHARGE_PHASE_ONE;
          end
        end
        `BSS_ST_FORCE: begin
          next_state = `BSS_ST_IDLE;
        end
        `BSS_ST_LINEAR_CHARGE_PHASE_ONE: begin
          if (i_input_undervoltage_lockout) begin
            next_state = `BSS_ST_IDLE;
          end else begin
            next_state = `BSS_ST_LINEAR_CHARGE_PHASE_TWO;
          end
        end
        `BSS_ST_LINEAR_CHARGE_PHASE_TWO: begin
          if (linear_charge_phase_two_expired) begin
            next_state = `BSS_ST_FAULT;
          end else if (!i_supply_in_above_out) begin
            next_state = `BSS_ST_START;
          end
        end
        `BSS_ST_START: begin
          next_state = `BSS_ST_SOFT;
        end
        `BSS_ST_SOFT: begin
          if (soft_expired) begin
            next_state = `BSS_ST_FAULT;
          end else if (i_out_at_target) begin
            next_state = `BSS_ST_BOOST;
          end
        end
        `BSS_ST_BOOST: begin
          if (i_supply_in_above_target) begin
            next_state = `BSS_ST_BYPASS;
          end
        end
        `BSS_ST_BYPASS: begin
          if (!i_supply_in_above_target) begin
            next_state = `BSS_ST_BOOST;
          end
        end
        `BSS_ST_FAULT: begin
          if (fault_expired) begin
            next_state = `BSS_ST_LINEAR_CHARGE_PHASE_ONE;
          end
        end
        default: begin
          next_state = `BSS_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // State and power stage outputs
  // ----------------------------------------
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= `BSS_ST_IDLE;
      prev_above <= 1'b1;
      o_power_ok_flag_out <= 1'b0;
      o_power_ok_flag_oe <= 1'b1;
      o_linear_charge_phase_one <= 1'b0;
      o_linear_charge_phase_two <= 1'b0;
      o_switch_enable <= 1'b0;
      o_ref_ramp <= 1'b0;
      o_bypass_fet_on <= 1'b0;
      o_target_high <= 1'b0;
      o_path_open <= 1'b1;
    end else begin
      state <= next_state;
      prev_above <= i_supply_in_above_out;
      o_power_ok_flag_out <= 1'b0;
      o_power_ok_flag_oe <= !(((next_state == `BSS_ST_BOOST) ||
                               (next_state == `BSS_ST_BYPASS)) && !overload);
      o_linear_charge_phase_one <= (next_state == `BSS_ST_LINEAR_CHARGE_PHASE_ONE);
      o_linear_charge_phase_two <= (next_state == `BSS_ST_LINEAR_CHARGE_PHASE_TWO);
      o_switch_enable <= (next_state == `BSS_ST_SOFT) || (next_state == `BSS_ST_BOOST);
      o_ref_ramp <= (next_state == `BSS_ST_SOFT);
      o_bypass_fet_on <= (next_state == `BSS_ST_BYPASS) || (next_state == `BSS_ST_FORCE);
      if (next_state == `BSS_ST_BOOST) begin
        o_target_high <= i_output_level_pick;
      end
      o_path_open <= (next_state == `BSS_ST_FAULT) || (next_state == `BSS_ST_IDLE);
    end
  end

  // ----------------------------------------
  // Interrupt events
  // ----------------------------------------
  always @* begin
    irq_set = 3'h0;
    irq_set[`BSS_IRQ_FAULT] = (next_state == `BSS_ST_FAULT) && (state != `BSS_ST_FAULT);
    irq_set[`BSS_IRQ_PWR_OK] = (next_state == `BSS_ST_BOOST) && (state == `BSS_ST_SOFT);
    irq_set[`BSS_IRQ_SHUTDOWN] = (next_state == `BSS_ST_IDLE) && (state != `BSS_ST_IDLE);
  end

  assign do_write = aw_held && w_held && !o_s_axi_bvalid;
  assign clear_bits = (do_write && (aw_addr == `BSS_REG_IRQ_STAT)) ? w_data[2:0] : 3'h0;

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_stat <= 3'h0;
      o_irq <= 1'b0;
    end else begin
      // Set wins over clear
      irq_stat <= (irq_stat & ~clear_bits) | irq_set;
      o_irq <= |(((irq_stat & ~clear_bits) | irq_set) & irq_mask);
    end
  end

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_addr <= 4'h0;
      aw_held <= 1'b0;
      w_data <= 32'h00000000;
      w_held <= 1'b0;
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready <= 1'b1;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= 2'h0;
      seq_on <= 1'b1;
      irq_mask <= `BSS_IRQ_MASK_RESET;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_addr <= i_s_axi_awaddr;
        aw_held <= 1'b1;
        o_s_axi_awready <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_data <= i_s_axi_wdata;
        w_held <= 1'b1;
        o_s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= 2'h0;
        if (aw_addr == `BSS_REG_CTRL) begin
          seq_on <= w_data[`BSS_CTRL_SEQ_ON];
        end else if (aw_addr == `BSS_REG_IRQ_MASK) begin
          irq_mask <= w_data[2:0];
        end else if (aw_addr == `BSS_REG_IRQ_STAT) begin
          o_s_axi_bresp <= 2'h0;
        end else if (aw_addr == `BSS_REG_STATUS) begin
          o_s_axi_bresp <= 2'h0;
        end else begin
          o_s_axi_bresp <= 2'h2;
        end
      end
      if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h00000000;
      o_s_axi_rresp <= 2'h0;
    end else begin
      if (i_s_axi_arvalid && o_s_axi_arready) begin
        o_s_axi_arready <= 1'b0;
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rresp <= 2'h0;
        if (i_s_axi_araddr == `BSS_REG_CTRL) begin
          o_s_axi_rdata <= {31'h00000000, seq_on};
        end else if (i_s_axi_araddr == `BSS_REG_STATUS) begin
          o_s_axi_rdata <= {24'h000000, !o_power_ok_flag_oe, o_path_open,
                            o_bypass_fet_on, o_target_high, state};
        end else if (i_s_axi_araddr == `BSS_REG_IRQ_STAT) begin
          o_s_axi_rdata <= {29'h00000000, irq_stat};
        end else if (i_s_axi_araddr == `BSS_REG_IRQ_MASK) begin
          o_s_axi_rdata <= {29'h00000000, irq_mask};
        end else begin
          o_s_axi_rdata <= 32'h00000000;
          o_s_axi_rresp <= 2'h2;
        end
      end
      if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
        o_s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* test/bss_sequencer_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module bss_sequencer_sva (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Pins
  input wire logic i_enable,
  input wire logic i_force_pass_low,
  input wire logic i_output_level_pick,
  input wire logic i_overcurrent,
  input wire logic i_overtemp,
  // Stage outputs
  input wire logic o_power_ok_flag_out,
  input wire logic o_power_ok_flag_oe,
  input wire logic o_linear_charge_phase_one,
  input wire logic o_linear_charge_phase_two,
  input wire logic o_switch_enable,
  input wire logic o_ref_ramp,
  input wire logic o_bypass_fet_on,
  input wire logic o_target_high,
  input wire logic o_path_open
);
  localparam int LINEAR_CHARGE_PHASE_TWO_MAX = 25602;
  localparam int SOFT_MAX = 50002;
  logic [15:0] linear_charge_phase_two_cnt;
  logic [15:0] soft_cnt;
  wire boost = o_switch_enable && !o_ref_ramp;
  wire run = i_enable && i_force_pass_low;
  // Phase length counters
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      linear_charge_phase_two_cnt <= 16'h0;
      soft_cnt <= 16'h0;
    end else begin
      linear_charge_phase_two_cnt <= o_linear_charge_phase_two ? linear_charge_phase_two_cnt + 16'h1 : 16'h0;
      soft_cnt <= o_ref_ramp ? soft_cnt + 16'h1 : 16'h0;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  a_shutdown_idle: assert property (
    !i_enable |=> o_path_open && !o_switch_enable && !o_bypass_fet_on && o_power_ok_flag_oe)
    else $error("shutdown outputs not idle");
  a_forced_pass: assert property (
    i_enable && !i_force_pass_low |=> o_bypass_fet_on && !o_switch_enable)
    else $error("forced pass not applied");
  a_overload_flag: assert property (
    i_overcurrent || i_overtemp |=> o_power_ok_flag_oe)
    else $error("flag not pulled on overload");
  a_level_pick: assert property (
    boost && $past(boost) |-> o_target_high == $past(i_output_level_pick))
    else $error("target level wrong");
  a_linear_charge_phase_one_once: assert property (
    $rose(o_linear_charge_phase_one) && run |=> o_linear_charge_phase_two
      && !o_linear_charge_phase_one)
    else $error("phase one not followed by two");
  a_linear_charge_phase_two_limit: assert property (linear_charge_phase_two_cnt <= LINEAR_CHARGE_PHASE_TWO_MAX)
    else $error("phase two too long");
  a_soft_limit: assert property (soft_cnt <= SOFT_MAX)
    else $error("soft start too long");
  a_soft_entry: assert property (
    $fell(o_linear_charge_phase_two) && !o_path_open && run |=> o_ref_ramp && o_switch_enable)
    else $error("soft start not entered");
  a_fet_split: assert property (
    !(o_switch_enable && o_bypass_fet_on) && (!o_ref_ramp || o_switch_enable))
    else $error("transistor use overlaps");
  a_flag_release: assert property (
    !o_power_ok_flag_oe |-> !o_power_ok_flag_out && (boost || o_bypass_fet_on))
    else $error("flag released outside regulation");
  c_soft: cover property ($rose(o_ref_ramp));
  c_good: cover property ($fell(o_power_ok_flag_oe));
  c_bypass: cover property ($rose(o_bypass_fet_on));
endmodule
bind bss_sequencer bss_sequencer_sva bss_sequencer_sva_i (.*);
`default_nettype wire

/* test/bss_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module bss_host_model (
  // Clock and requests
  input wire logic i_clock,
  input wire logic i_want_enable,
  input wire logic i_want_auto,
  // Power-good pin
  input wire logic i_flag_out,
  input wire logic i_flag_oe,
  // Pins
  output logic o_enable,
  output logic o_force_pass_low,
  output wire logic o_power_ok
);
  localparam int HOLD = 1501;
  int n;
  initial begin
    o_enable = 1'b0;
    o_force_pass_low = 1'b1;
    n = 0;
  end
  always @(posedge i_clock) begin
    o_enable <= i_want_enable;
    n <= o_enable ? n + 1 : 0;
    o_force_pass_low <= i_want_auto && (n > HOLD);
  end
  assign o_power_ok = i_flag_oe ? i_flag_out : 1'b1;
endmodule
`default_nettype wire

/* test/test_boost_startup_mode_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module test_boost_startup_mode_sequencer;
  logic i_clock, i_nrst, i_enable, i_force_pass_low, i_output_level_pick;
  logic i_supply_in_above_out, i_supply_in_above_target, i_input_undervoltage_lockout;
  logic i_out_at_target, i_overcurrent, i_overtemp, i_s_axi_awvalid, i_s_axi_wvalid;
  logic i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready, want_en, want_auto, pok;
  logic [3:0] i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wstrb;
  logic [31:0] i_s_axi_wdata, o_s_axi_rdata, rd;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, rr, br;
  logic o_power_ok_flag_out, o_power_ok_flag_oe, o_linear_charge_phase_one;
  logic o_linear_charge_phase_two, o_switch_enable, o_ref_ramp, o_bypass_fet_on;
  logic o_target_high, o_path_open, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
  logic o_s_axi_arready, o_s_axi_rvalid, o_irq;
  int fails, compares, cyc, n, k;
  wire [5:0] stg = {o_linear_charge_phase_one, o_linear_charge_phase_two, o_switch_enable,
    o_ref_ramp, o_bypass_fet_on, o_path_open};
  bss_sequencer bss_sequencer_i (.*);
  bss_host_model bss_host_model_i (.i_clock(i_clock), .i_want_enable(want_en),
    .i_want_auto(want_auto), .i_flag_out(o_power_ok_flag_out), .i_flag_oe(o_power_ok_flag_oe),
    .o_enable(i_enable), .o_force_pass_low(i_force_pass_low), .o_power_ok(pok));
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tick(input int c);
    repeat (c) @(posedge i_clock);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge i_clock);
      if (aw && o_s_axi_awready === 1'b1) begin aw = 1'b0; i_s_axi_awvalid <= 1'b0; end
      if (w && o_s_axi_wready === 1'b1) begin w = 1'b0; i_s_axi_wvalid <= 1'b0; end
    end
    do @(posedge i_clock); while (o_s_axi_bvalid !== 1'b1);
    br = o_s_axi_bresp;
    i_s_axi_bready <= 1'b0;
    @(posedge i_clock);
  endtask
  task rdr(input logic [3:0] a);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do @(posedge i_clock); while (o_s_axi_arready !== 1'b1);
    i_s_axi_arvalid <= 1'b0;
    do @(posedge i_clock); while (o_s_axi_rvalid !== 1'b1);
    rd = o_s_axi_rdata;
    rr = o_s_axi_rresp;
    i_s_axi_rready <= 1'b0;
    @(posedge i_clock);
  endtask
  task print_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin fails++; print_verdict; end
  end
  initial begin
    {i_nrst, i_output_level_pick, i_supply_in_above_out, i_supply_in_above_target} = 4'h0;
    {i_input_undervoltage_lockout, i_out_at_target, i_overcurrent, i_overtemp} = 4'h0;
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid} = 4'h0;
    {i_s_axi_rready, want_en, want_auto} = 3'h0;
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = 40'h0;
    i_s_axi_wstrb = 4'hf;
    {fails, compares, cyc} = 96'h0;
    tick(8);
    i_nrst <= 1'b1;
    rdr(4'h4); chk("status", rd, 32'h40);
    rdr(4'h0); chk("ctrl", rd, 32'h1);
    rdr(4'hc); chk("mask", rd, 32'h0);
    rdr(4'h2); chk("unmapped", {30'h0, rr}, 32'h2);
    wr(4'h2, 32'h0); chk("wr unmapped", {30'h0, br}, 32'h2);
    $display("test reset done");
    wr(4'hc, 32'h6); chk("wr resp", {30'h0, br}, 32'h0);
    rdr(4'hc); chk("mask set", rd, 32'h6);
    want_en <= 1'b1;
    want_auto <= 1'b1;
    tick(1600);
    wr(4'h8, 32'h7);
    i_supply_in_above_out <= 1'b1;
    tick(2); chk("linear_charge_phase_one", stg, 6'h20);
    tick(1); chk("linear_charge_phase_two", stg, 6'h10);
    i_supply_in_above_out <= 1'b0;
    tick(3); chk("soft", stg, 6'h0c);
    i_out_at_target <= 1'b1;
    tick(2); chk("boost", {stg, pok}, 7'h11);
    tick(1); chk("irq", o_irq, 1'b1);
    rdr(4'h8); chk("irq stat", rd, 32'h2);
    wr(4'h8, 32'h2);
    tick(2); chk("irq clr", o_irq, 1'b0);
    $display("test startup done");
    i_output_level_pick <= 1'b1;
    tick(3); chk("pick high", o_target_high, 1'b1);
    i_output_level_pick <= 1'b0;
    tick(3); chk("pick low", o_target_high, 1'b0);
    i_supply_in_above_target <= 1'b1;
    tick(2); chk("bypass", {stg, pok}, 7'h05);
    i_supply_in_above_target <= 1'b0;
    tick(2); chk("back", stg, 6'h08);
    for (k = 0; k < 2; k++) begin
      {i_overtemp, i_overcurrent} <= 2'h1 << k;
      tick(2); chk("overload", pok, 1'b0);
      {i_overtemp, i_overcurrent} <= 2'h0;
      tick(2); chk("recover", pok, 1'b1);
    end
    $display("test modes done");
    want_auto <= 1'b0;
    tick(3); chk("forced", stg, 6'h02);
    want_auto <= 1'b1;
    tick(3); chk("auto", stg, 6'h01);
    wr(4'h8, 32'h7);
    i_out_at_target <= 1'b0;
    i_input_undervoltage_lockout <= 1'b1;
    i_supply_in_above_out <= 1'b1;
    tick(3); chk("locked", stg, 6'h01);
    i_input_undervoltage_lockout <= 1'b0;
    i_supply_in_above_out <= 1'b0;
    tick(2);
    i_supply_in_above_out <= 1'b1;
    tick(3); chk("linear_charge_phase_two again", stg, 6'h10);
    n = 0;
    while (o_linear_charge_phase_two === 1'b1 && n < 30000) begin tick(1); n++; end
    chk("linear_charge_phase_two time", n > 25590 && n < 25610, 1'b1);
    chk("fault", {stg, pok}, 7'h02);
    rdr(4'h8); chk("fault stat", rd, 32'h1);
    chk("masked", o_irq, 1'b0);
    n = 0;
    while (o_linear_charge_phase_one !== 1'b1 && n < 30000) begin tick(1); n++; end
    chk("fault time", n > 24990 && n < 25010, 1'b1);
    $display("test fault done");
    wr(4'h0, 32'h0);
    tick(2); chk("seq off", stg, 6'h01);
    wr(4'h0, 32'h1);
    rdr(4'h0); chk("ctrl back", rd, 32'h1);
    want_en <= 1'b0;
    tick(3); chk("off", {stg, pok}, 7'h02);
    rdr(4'h4); chk("off status", rd, 32'h40);
    $display("test shutdown done");
    print_verdict;
  end
endmodule
`default_nettype wire
